// *** verilog/crossbar_defines.vh ***
// constants shared by the crossbar arbiter and its memory port selector
`ifndef CROSSBAR_DEFINES_VH
`define CROSSBAR_DEFINES_VH
`define XB_NUM_MASTERS   3
`define XB_M_CPU         0
`define XB_M_DME         1
`define XB_M_HOST        2
`define XB_NUM_TARGETS   2
`define XB_T_MEM         0
`define XB_T_PERIPH      1
`define XB_ADDR_W        32
`define XB_PAGE_SHIFT    16
`define XB_PAGE_W        16
`define XB_PAGE_RESET    16'h0000
`define XB_MEM_SRC_NUM   4
`define XB_MEM_MAX_PAR   3
`define XB_CPU_DATA_W    64
`define XB_FETCH_W       256
`define XB_PERIPH_W      32
`endif

// *** verilog/mem_port_select.v ***
// memory controller source acceptance: up to three of four sources per cycle
`timescale 1ns/1ps
`include "crossbar_defines.vh"
module mem_port_select #(
  parameter SRC_NUM = `XB_MEM_SRC_NUM,
  parameter MAX_PAR = `XB_MEM_MAX_PAR
) (
  input  wire [SRC_NUM-1:0] req_i,
  output wire [SRC_NUM-1:0] accept_o
);
  // priority: peripheral port (top source) first, then cpu data 0, cpu data 1, fetch
  reg     [SRC_NUM-1:0] acc;
  integer               n;
  integer               k;
  always @* begin
    acc = {SRC_NUM{1'b0}};
    n   = 0;
    if (req_i[SRC_NUM-1]) begin
      acc[SRC_NUM-1] = 1'b1;
      n              = 1;
    end
    for (k = 0; k < SRC_NUM - 1; k = k + 1) begin
      if (req_i[k] && n < MAX_PAR) begin
        acc[k] = 1'b1;
        n      = n + 1;
      end
    end
  end
  assign accept_o = acc;
endmodule

// *** verilog/crossbar_priority_arbiter.v ***
// fixed-priority crossbar arbiter for cpu, data movement engine and host access port
`timescale 1ns/1ps
`include "crossbar_defines.vh"
//////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - masters addressing different targets are granted in the same cycle
// - contention for one target resolved by fixed priority, never rotating
// - priority order is data movement engine, then host port, then cpu
// - host access port has no path to peripheral targets
// - memory accepts up to three of four sources at once
// - peripheral-side memory port serves engine or host, never both
// - host access restricted to one 64K page while host_page_en_i is set, page changed only by cpu
module crossbar_priority_arbiter #(
  parameter ADDR_W     = `XB_ADDR_W,
  parameter PAGE_SHIFT = `XB_PAGE_SHIFT,
  parameter PAGE_W     = `XB_PAGE_W
) (
  input  wire              clk_i,
  input  wire              rst_b_i,
  input  wire              cpu_req_i,
  input  wire              cpu_tgt_i,
  input  wire              cpu_last_i,
  input  wire              cpu_page_we_i,
  input  wire [PAGE_W-1:0] cpu_page_i,
  input  wire              dme_req_i,
  input  wire              dme_tgt_i,
  input  wire              dme_last_i,
  input  wire              host_req_i,
  input  wire              host_tgt_i,
  input  wire [ADDR_W-1:0] host_addr_i,
  input  wire              host_last_i,
  input  wire              host_page_en_i,
  input  wire              cpu_dat0_req_i,
  input  wire              cpu_dat1_req_i,
  input  wire              fetch_req_i,
  output wire              cpu_gnt_o,
  output wire              dme_gnt_o,
  output wire              host_gnt_o,
  output wire              host_err_o,
  output wire [3:0]        mem_accept_o,
  output wire [1:0]        mem_periph_owner_o,
  output reg  [PAGE_W-1:0] host_page_o
);
  //////////////////////////////////////////////////////////////////////////////
  // reset release
  reg        rst_s1;
  reg        rst_s2;
  wire       rst;
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_s1 <= 1'b1;
      rst_s2 <= 1'b1;
    end else begin
      rst_s1 <= 1'b0;
      rst_s2 <= rst_s1;
    end
  end
  assign rst = rst_s2;

  //////////////////////////////////////////////////////////////////////////////
  // host page window
  always @(posedge clk_i or posedge rst) begin
    if (rst) begin
      host_page_o <= `XB_PAGE_RESET;
    end else if (cpu_page_we_i) begin
      host_page_o <= cpu_page_i;
    end
  end
  wire host_page_ok;
  wire host_bad;
  wire host_ok_req;
  assign host_page_ok = !host_page_en_i || (host_addr_i[ADDR_W-1:PAGE_SHIFT] == host_page_o);
  assign host_bad     = host_req_i && (host_tgt_i == `XB_T_PERIPH || !host_page_ok);
  assign host_ok_req  = host_req_i && !host_bad;
  assign host_err_o   = host_bad && !rst;

  //////////////////////////////////////////////////////////////////////////////
  // per-target arbitration
  function [2:0] pick;
    input [2:0] r;
    begin
      if (r[`XB_M_DME]) begin
        pick = 3'h2;
      end else if (r[`XB_M_HOST]) begin
        pick = 3'h4;
      end else if (r[`XB_M_CPU]) begin
        pick = 3'h1;
      end else begin
        pick = 3'h0;
      end
    end
  endfunction

  wire [2:0]                   lasts;
  wire [3*`XB_NUM_TARGETS-1:0] won;
  assign lasts = {host_last_i, dme_last_i, cpu_last_i};
  genvar t;
  generate
    for (t = 0; t < `XB_NUM_TARGETS; t = t + 1) begin : g_tgt
      reg  [2:0] owner;
      wire [2:0] r;
      wire [2:0] live;
      wire [2:0] next_owner;
      assign r = {host_ok_req && host_tgt_i == t, dme_req_i && dme_tgt_i == t, cpu_req_i && cpu_tgt_i == t};
      // a held owner keeps the target until its last beat; a dropped request frees it
      assign live          = ((owner & r) != 3'h0) ? owner : pick(r);
      assign won[3*t +: 3] = rst ? 3'h0 : (live & r);
      assign next_owner    = ((live & lasts & r) != 3'h0) ? 3'h0 : (live & r);
      always @(posedge clk_i or posedge rst) begin
        if (rst) begin
          owner <= 3'h0;
        end else begin
          owner <= next_owner;
        end
      end
    end
  endgenerate

  // independent targets grant in parallel; nothing is granted in reset
  wire [2:0] gnt;
  wire [2:0] mem_won;
  assign gnt        = won[3*`XB_T_MEM +: 3] | won[3*`XB_T_PERIPH +: 3];
  assign mem_won    = won[3*`XB_T_MEM +: 3];
  assign cpu_gnt_o  = gnt[`XB_M_CPU];
  assign dme_gnt_o  = gnt[`XB_M_DME];
  assign host_gnt_o = gnt[`XB_M_HOST];

  //////////////////////////////////////////////////////////////////////////////
  // memory controller sources
  wire       periph_mem;
  wire [3:0] mem_req;
  assign periph_mem         = mem_won[`XB_M_DME] || mem_won[`XB_M_HOST];
  assign mem_periph_owner_o = {mem_won[`XB_M_HOST], mem_won[`XB_M_DME]};
  assign mem_req            = rst ? 4'h0 : {periph_mem, fetch_req_i, cpu_dat1_req_i, cpu_dat0_req_i};
  mem_port_select #(
    .SRC_NUM (`XB_MEM_SRC_NUM),
    .MAX_PAR (`XB_MEM_MAX_PAR)
  ) u_sel (
    .req_i    (mem_req),
    .accept_o (mem_accept_o)
  );
endmodule

// *** dv/crossbar_priority_arbiter_properties.sv ***
// port checker for the crossbar arbiter
`timescale 1ns/1ps
module crossbar_priority_arbiter_properties (
  input logic        clk_i, rst_b_i, cpu_req_i, cpu_tgt_i, cpu_last_i, cpu_page_we_i,
  input logic        dme_req_i, dme_tgt_i, host_req_i, host_tgt_i,
  input logic        cpu_gnt_o, dme_gnt_o, host_gnt_o, host_err_o,
  input logic [15:0] cpu_page_i, host_page_o,
  input logic [3:0]  mem_accept_o,
  input logic [1:0]  mem_periph_owner_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  par_grant_a: assert property (cpu_gnt_o && !cpu_tgt_i && dme_req_i && dme_tgt_i |-> dme_gnt_o)
    else $error("no parallel grant");
  one_owner_a: assert property ($onehot0({cpu_gnt_o && !cpu_tgt_i, dme_gnt_o && !dme_tgt_i, host_gnt_o}))
    else $error("two memory owners");
  dme_first_a: assert property ($rose(cpu_gnt_o) |-> !(dme_req_i && dme_tgt_i == cpu_tgt_i))
    else $error("cpu beat engine");
  host_first_a: assert property ($rose(cpu_gnt_o) && !cpu_tgt_i |-> !(host_req_i && !host_err_o))
    else $error("cpu beat host");
  host_block_a: assert property (host_req_i && host_tgt_i |-> host_err_o && !host_gnt_o)
    else $error("host reached periph");
  mem_cap_a: assert property ($countones(mem_accept_o) <= 3)
    else $error("too many accepts");
  port_owner_a: assert property (mem_periph_owner_o != 2'b11)
    else $error("shared periph port");
  page_load_a: assert property (cpu_page_we_i |=> host_page_o == $past(cpu_page_i))
    else $error("page not loaded");
  no_preempt_a: assert property (cpu_gnt_o && !cpu_last_i |=> cpu_gnt_o || !cpu_req_i)
    else $error("grant preempted");
  cover property (dme_gnt_o && cpu_req_i);
  cover property (host_err_o);
  cover property (cpu_gnt_o && dme_gnt_o);
  cover property (host_gnt_o && cpu_req_i);
endmodule

// *** dv/master_model.sv ***
// bus master model: request on go, two beats per transfer
`timescale 1ns/1ps
module master_model (
  input  wire clk_i,
  input  wire go_i,
  input  wire gnt_i,
  output reg  req_o,
  output wire last_o
);
  reg beat = 1'b0;
  initial req_o = 1'b0;
  assign last_o = gnt_i & beat;
  always @(posedge clk_i) begin
    beat <= gnt_i & ~last_o;
    if (go_i)
      req_o <= 1'b1;
    else if (last_o)
      req_o <= 1'b0;
  end
endmodule

// *** dv/crossbar_priority_arbiter_tb.sv ***
// self-checking bench for the crossbar arbiter
`timescale 1ns/1ps
module crossbar_priority_arbiter_tb;
  logic        clk_i = 0, rst_b_i = 0, page_we = 0, page_en = 0, dat0 = 0, dat1 = 0, fetch = 0;
  logic [2:0]  go = 0, tgt = 0;
  logic [15:0] page = 16'h0000;
  logic [31:0] addr = 32'h0000_0000;
  wire         err;
  wire  [2:0]  req, last, gnt;
  wire  [1:0]  owner;
  wire  [3:0]  accept;
  wire  [15:0] host_page;
  int          error_cnt = 0, checks_done = 0, cyc_cnt = 0;
  initial forever #2 clk_i = ~clk_i;
  master_model u_m[2:0] (.clk_i(clk_i), .go_i(go), .gnt_i(gnt), .req_o(req), .last_o(last));
  crossbar_priority_arbiter u_dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .cpu_req_i(req[0]), .cpu_tgt_i(tgt[0]),
    .cpu_last_i(last[0]), .cpu_page_we_i(page_we), .cpu_page_i(page), .dme_req_i(req[1]), .dme_tgt_i(tgt[1]),
    .dme_last_i(last[1]), .host_req_i(req[2]), .host_tgt_i(tgt[2]), .host_addr_i(addr), .host_last_i(last[2]),
    .host_page_en_i(page_en), .cpu_dat0_req_i(dat0), .cpu_dat1_req_i(dat1), .fetch_req_i(fetch),
    .cpu_gnt_o(gnt[0]), .dme_gnt_o(gnt[1]), .host_gnt_o(gnt[2]), .host_err_o(err),
    .mem_accept_o(accept), .mem_periph_owner_o(owner), .host_page_o(host_page));
  task cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task chk(input logic ok);
    checks_done++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("ERROR %0t mismatch", $time);
    end
  endtask
  task contend;
    go = 3'b111;
    cyc(1);
    go = 0;
    chk(gnt === 3'b010 && req === 3'b111);
    chk(owner === 2'b01);
    cyc(2);
    chk(gnt === 3'b100);
    chk(owner === 2'b10);
    cyc(2);
    chk(gnt === 3'b001);
    cyc(2);
  endtask
  task parallel_targets;
    tgt = 3'b010;
    go = 3'b011;
    cyc(1);
    go = 0;
    chk(gnt === 3'b011);
    cyc(2);
  endtask
  task host_page_use;
    tgt = 3'b100;
    go = 3'b100;
    cyc(1);
    go = 0;
    chk(err && !gnt[2]);
    page = 16'h1234;
    page_we = 1;
    cyc(1);
    page_we = 0;
    chk(host_page === 16'h1234);
    tgt = 0;
    page_en = 1;
    addr = 32'h5678_0010;
    cyc(1);
    chk(err && !gnt[2]);
    addr = 32'h1234_0010;
    cyc(1);
    chk(gnt[2] && !err);
    cyc(2);
  endtask
  task mem_src;
    {dat0, dat1, fetch} = 3'b111;
    cyc(1);
    chk(accept === 4'h7);
    go = 3'b010;
    cyc(1);
    go = 0;
    chk(accept === 4'hB);
    chk(owner === 2'b01);
    cyc(2);
  endtask
  initial begin
    cyc(16);
    rst_b_i = 1;
    cyc(3);
    contend;
    parallel_targets;
    host_page_use;
    mem_src;
    report_and_stop;
  end
  always @(posedge clk_i) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 500) begin
      error_cnt++;
      report_and_stop;
    end
  end
  task report_and_stop;
    $display("errors %0d checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
endmodule
bind crossbar_priority_arbiter crossbar_priority_arbiter_properties u_props (.*);
